//--- core/fwpg_pkg.sv
// Constants and types shared by the flash write-protect gating block
package fwpg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Array geometry: 33,554,432 bytes, 512 blocks of 64 KB, 4 KB sectors
  localparam int ADDR_W = 25;
  localparam int BLK_LSB = 16;
  localparam int SECT_LSB = 12;
  localparam int BLK_W = 9;
  localparam int SECT_W = 4;
  localparam int BLOCKS = 512;
  localparam int SECT_PER_BLK = 16;
  localparam int PAGE_BYTES_DFLT = 256;
  localparam logic [BLK_W-1:0] BLK_LOWEST = 9'h000;
  localparam logic [BLK_W-1:0] BLK_HIGHEST = 9'h1FF;

  ////////////////////////////////////////////////////////////////////////////
  // Protect level decoding
  localparam logic [3:0] LEVEL_NONE = 4'h0;
  localparam logic [3:0] LEVEL_ALL_MIN = 4'hA;
  localparam logic [9:0] BLOCKS_TOTAL = 10'h200;

  ////////////////////////////////////////////////////////////////////////////
  // Command codes
  localparam logic [7:0] CMD_PROG3 = 8'h02;
  localparam logic [7:0] CMD_PROG4 = 8'h12;
  localparam logic [7:0] CMD_SECT_ERASE3 = 8'h20;
  localparam logic [7:0] CMD_SECT_ERASE4 = 8'h21;
  localparam logic [7:0] CMD_BLK_ERASE3 = 8'hD8;
  localparam logic [7:0] CMD_BLK_ERASE4 = 8'hDC;
  localparam logic [7:0] CMD_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] CMD_CHIP_ERASE_B = 8'hC7;
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_POWER_DOWN = 8'hB9;
  localparam logic [7:0] CMD_POWER_UP = 8'hAB;
  localparam logic [7:0] CMD_NO_OP = 8'h00;
  localparam logic [7:0] CMD_RESET_ARM = 8'h66;
  localparam logic [7:0] CMD_RESET_GO = 8'h99;

  // Address bytes carried by each addressed command
  localparam logic [2:0] ALEN_SHORT = 3'h3;
  localparam logic [2:0] ALEN_LONG = 3'h4;
  localparam logic [2:0] ALEN_NONE = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic RST_WEL = 1'b0;
  localparam logic RST_WIP = 1'b0;
  localparam logic RST_DPD = 1'b0;
  localparam logic RST_STANDBY = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    ST_STANDBY = 3'b000,
    ST_CMD = 3'b001,
    ST_CMD2 = 3'b010,
    ST_ADDR = 3'b011,
    ST_DATA = 3'b100,
    ST_IGNORE = 3'b101
  } fwpg_state_type;

  typedef enum logic [1:0] {
    KIND_PROG = 2'b00,
    KIND_SECTOR = 2'b01,
    KIND_BLOCK = 2'b10,
    KIND_CHIP = 2'b11
  } fwpg_kind_type;

endpackage : fwpg_pkg

//--- core/fwpg_core.sv
// Command gating and write protection for the serial NOR flash
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// (RULE1) Single-wire frames open with a one-byte command code.
// (RULE2) Octal frames open with a two-byte command code.
// (RULE3) Check length in single mode, complement of second byte in octal.
// (RULE4) Data-changing commands refused unless write-enable latch is set.
// (RULE5) In deep power-down only release and software reset are obeyed.
// (RULE6) Command state machine starts in standby after reset.
// (RULE7) Array changes only after a complete valid sequence.
// (RULE8) Standby when chip select is high and nothing runs.
// (RULE9) Program one byte, a word or up to a 256-byte page.
// (RULE10) Erase a 4 KB sector, a 64 KB block or the whole chip.
// (RULE11) Accepted program or erase runs the internal perform-verify cycle.
// (RULE12) Write-in-progress flag shows a running program or erase.
// (RULE13) Bottom select clear: level n protects top 2^(n-1) blocks.
// (RULE14) Levels 10 to 15 protect all 512 blocks.
// (RULE15) Program or erase aimed into the protected area is refused.
// (RULE16) Single mode uses clock, data in, data out and active-low select.
// (RULE17) Sector locks in the 16-sector extreme blocks, block locks elsewhere.
// (RULE18) Array is 33,554,432 bytes of eight bits.
// (RULE19) Bottom select set: level n protects 2^(n-1) blocks from block 0.
// (RULE20) Block index checked against protected range before start.
module fwpg_core #(
  parameter int PAGE_BYTES = fwpg_pkg::PAGE_BYTES_DFLT,
  parameter int PAGE_AW = $clog2(PAGE_BYTES)
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic [7:0] sio_pin,
  input wire logic octal_mode,
  input wire logic [3:0] protect_level_bits,
  input wire logic top_bottom_select,
  input wire logic [fwpg_pkg::BLOCKS-1:0] block_lock_bits,
  input wire logic [fwpg_pkg::SECT_PER_BLK-1:0] sector_lock_bottom,
  input wire logic [fwpg_pkg::SECT_PER_BLK-1:0] sector_lock_top,
  input wire logic [PAGE_AW-1:0] buf_rd_index,
  input wire logic op_done,
  input wire logic op_verify_ok,
  output logic op_start_q,
  output logic [1:0] op_kind_q,
  output logic [fwpg_pkg::ADDR_W-1:0] op_addr_q,
  output logic [PAGE_AW:0] op_count_q,
  output logic [7:0] buf_rd_data_q,
  output logic write_enable_latch_q,
  output logic write_in_progress_flag_q,
  output logic deep_power_down_q,
  output logic standby_q,
  output logic cmd_rejected_q,
  output logic op_failed_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter checks
  generate
    if (PAGE_BYTES < 2 || PAGE_BYTES > 256 ||
        (PAGE_BYTES & (PAGE_BYTES - 1)) != 0 ||
        PAGE_AW != $clog2(PAGE_BYTES)) begin : g_bad_page
      $error("fwpg_core: PAGE_BYTES must be a power of two up to 256");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the third stage only feeds edge detection
  logic cs_s1_q, cs_s2_q, cs_s3_q;
  logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
  logic [7:0] sio_s1_q, sio_s2_q;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
      sio_s1_q <= 8'h00;
      sio_s2_q <= 8'h00;
    end else begin
      cs_s1_q <= cs_n_pin;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      sclk_s1_q <= sclk_pin;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      sio_s1_q <= sio_pin;
      sio_s2_q <= sio_s1_q;
    end
  end

  logic frame_start, frame_end, sclk_rise;
  assign frame_start = !cs_s2_q && cs_s3_q;
  assign frame_end = cs_s2_q && !cs_s3_q;
  // Access only while select is low [RULE16]
  assign sclk_rise = sclk_s2_q && !sclk_s3_q && !cs_s2_q;

  ////////////////////////////////////////////////////////////////////////////
  // Byte assembly, MSB first; mode is frozen at select fall
  logic oct_q;
  logic [2:0] bit_cnt_q;
  logic [6:0] shift_q;
  logic byte_valid;
  logic [7:0] byte_val;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      oct_q <= 1'b0;
    end else if (frame_start) begin
      oct_q <= octal_mode;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n || frame_start) begin
      bit_cnt_q <= 3'h0;
      shift_q <= 7'h00;
    end else if (sclk_rise && !oct_q) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shift_q <= {shift_q[5:0], sio_s2_q[0]};
    end
  end

  // Octal mode takes a whole byte per rising edge
  assign byte_valid = sclk_rise && (oct_q || bit_cnt_q == 3'h7);
  assign byte_val = oct_q ? sio_s2_q : {shift_q, sio_s2_q[0]};

  ////////////////////////////////////////////////////////////////////////////
  // Command decode
  fwpg_pkg::fwpg_state_type state_q;
  logic [7:0] cmd_q;
  logic [7:0] cmd_now;
  logic [2:0] alen;
  logic known, blocked_dpd;
  fwpg_pkg::fwpg_state_type hdr_next;

  assign cmd_now = (state_q == fwpg_pkg::ST_CMD) ? byte_val : cmd_q;

  always_comb begin
    alen = fwpg_pkg::ALEN_NONE;
    known = 1'b1;
    case (cmd_now)
      fwpg_pkg::CMD_PROG3, fwpg_pkg::CMD_SECT_ERASE3,
      fwpg_pkg::CMD_BLK_ERASE3: begin
        // Octal frames always carry four address bytes
        alen = oct_q ? fwpg_pkg::ALEN_LONG : fwpg_pkg::ALEN_SHORT;
      end
      fwpg_pkg::CMD_PROG4, fwpg_pkg::CMD_SECT_ERASE4,
      fwpg_pkg::CMD_BLK_ERASE4: begin
        alen = fwpg_pkg::ALEN_LONG;
      end
      fwpg_pkg::CMD_CHIP_ERASE_A, fwpg_pkg::CMD_CHIP_ERASE_B,
      fwpg_pkg::CMD_WRITE_ENABLE, fwpg_pkg::CMD_WRITE_DISABLE,
      fwpg_pkg::CMD_POWER_DOWN, fwpg_pkg::CMD_POWER_UP,
      fwpg_pkg::CMD_NO_OP, fwpg_pkg::CMD_RESET_ARM,
      fwpg_pkg::CMD_RESET_GO: begin
        alen = fwpg_pkg::ALEN_NONE;
      end
      default: begin
        known = 1'b0;
      end
    endcase
  end

  assign blocked_dpd = deep_power_down_q &&
    cmd_now != fwpg_pkg::CMD_POWER_UP &&
    cmd_now != fwpg_pkg::CMD_RESET_ARM &&
    cmd_now != fwpg_pkg::CMD_RESET_GO; // [RULE5]

  always_comb begin
    if (!known || blocked_dpd) begin
      hdr_next = fwpg_pkg::ST_IGNORE;
    end else if (alen != fwpg_pkg::ALEN_NONE) begin
      hdr_next = fwpg_pkg::ST_ADDR;
    end else begin
      hdr_next = fwpg_pkg::ST_DATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame state machine; a bad frame parks in ignore until select rises
  logic [2:0] addr_left_q;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q <= fwpg_pkg::ST_STANDBY; // [RULE6]
    end else if (frame_end) begin
      state_q <= fwpg_pkg::ST_STANDBY; // [RULE8]
    end else if (frame_start) begin
      state_q <= fwpg_pkg::ST_CMD;
    end else if (byte_valid) begin
      case (state_q)
        fwpg_pkg::ST_CMD: begin
          // One code byte in single mode, two in octal [RULE1] [RULE2]
          state_q <= oct_q ? fwpg_pkg::ST_CMD2 : hdr_next;
        end
        fwpg_pkg::ST_CMD2: begin
          state_q <= (byte_val == ~cmd_q) ? hdr_next
                                          : fwpg_pkg::ST_IGNORE; // [RULE3]
        end
        fwpg_pkg::ST_ADDR: begin
          if (addr_left_q == 3'h1) begin
            state_q <= fwpg_pkg::ST_DATA;
          end
        end
        default: begin
          state_q <= state_q;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cmd_q <= fwpg_pkg::CMD_NO_OP;
    end else if (byte_valid && state_q == fwpg_pkg::ST_CMD) begin
      cmd_q <= byte_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address and page data capture
  logic [fwpg_pkg::ADDR_W-1:0] addr_q;
  logic [PAGE_AW:0] data_cnt_q;
  logic extra_q;
  logic [7:0] buf_q [PAGE_BYTES];
  logic is_prog, is_sect, is_blk, is_chip, alters;
  logic hdr_done;

  assign is_prog = cmd_q == fwpg_pkg::CMD_PROG3 ||
                   cmd_q == fwpg_pkg::CMD_PROG4;
  assign is_sect = cmd_q == fwpg_pkg::CMD_SECT_ERASE3 ||
                   cmd_q == fwpg_pkg::CMD_SECT_ERASE4;
  assign is_blk = cmd_q == fwpg_pkg::CMD_BLK_ERASE3 ||
                  cmd_q == fwpg_pkg::CMD_BLK_ERASE4;
  assign is_chip = cmd_q == fwpg_pkg::CMD_CHIP_ERASE_A ||
                   cmd_q == fwpg_pkg::CMD_CHIP_ERASE_B;
  assign alters = is_prog || is_sect || is_blk || is_chip;
  assign hdr_done = byte_valid && (state_q == fwpg_pkg::ST_CMD2 ||
    (state_q == fwpg_pkg::ST_CMD && !oct_q));

  always_ff @(posedge clock) begin
    if (!rst_n || frame_start) begin
      addr_left_q <= 3'h0;
      addr_q <= '0;
    end else if (hdr_done) begin
      addr_left_q <= alen;
    end else if (byte_valid && state_q == fwpg_pkg::ST_ADDR) begin
      addr_left_q <= addr_left_q - 3'h1;
      // The upper seven bits of a four-byte address fall off above the array; its lowest bit stays as address bit 24
      addr_q <= {addr_q[fwpg_pkg::ADDR_W-9:0], byte_val}; // [RULE18]
    end
  end

  // Data past a page end wraps and overwrites; count stops at one page
  always_ff @(posedge clock) begin
    if (!rst_n || frame_start) begin
      data_cnt_q <= '0;
      extra_q <= 1'b0;
    end else if (byte_valid && state_q == fwpg_pkg::ST_DATA) begin
      if (!is_prog) begin
        extra_q <= 1'b1; // [RULE3]
      end else if (data_cnt_q != (PAGE_AW+1)'(PAGE_BYTES)) begin
        data_cnt_q <= data_cnt_q + (PAGE_AW+1)'(1); // [RULE9]
      end
    end
  end

  // Page buffer holds data until the frame proves complete
  always_ff @(posedge clock) begin
    if (byte_valid && state_q == fwpg_pkg::ST_DATA && is_prog) begin
      buf_q[addr_q[PAGE_AW-1:0] + data_cnt_q[PAGE_AW-1:0]] <= byte_val;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      buf_rd_data_q <= 8'h00;
    end else begin
      buf_rd_data_q <= buf_q[buf_rd_index];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protected area from level bits, bottom select and lock bits
  logic [fwpg_pkg::BLK_W-1:0] blk;
  logic [fwpg_pkg::SECT_W-1:0] sect;
  logic [9:0] lvl_cnt;
  logic lvl_hit, lock_hit, prot_hit;

  assign blk = addr_q[fwpg_pkg::ADDR_W-1:fwpg_pkg::BLK_LSB];
  assign sect = addr_q[fwpg_pkg::BLK_LSB-1:fwpg_pkg::SECT_LSB];
  assign lvl_cnt = 10'h001 << (protect_level_bits - 4'h1);

  always_comb begin
    if (protect_level_bits == fwpg_pkg::LEVEL_NONE) begin
      lvl_hit = 1'b0; // [RULE13]
    end else if (is_chip) begin
      lvl_hit = 1'b1;
    end else if (protect_level_bits >= fwpg_pkg::LEVEL_ALL_MIN) begin
      lvl_hit = 1'b1; // [RULE14]
    end else if (top_bottom_select) begin
      lvl_hit = {1'b0, blk} < lvl_cnt; // [RULE19] [RULE20]
    end else begin
      lvl_hit = {1'b0, blk} >=
                (fwpg_pkg::BLOCKS_TOTAL - lvl_cnt); // [RULE13] [RULE20]
    end
  end

  // Extreme blocks lock per 4 KB sector, all others per 64 KB block
  always_comb begin
    if (is_chip) begin
      lock_hit = |block_lock_bits || |sector_lock_bottom ||
                 |sector_lock_top;
    end else if (blk == fwpg_pkg::BLK_LOWEST) begin
      lock_hit = is_blk ? |sector_lock_bottom
                        : sector_lock_bottom[sect]; // [RULE17]
    end else if (blk == fwpg_pkg::BLK_HIGHEST) begin
      lock_hit = is_blk ? |sector_lock_top
                        : sector_lock_top[sect]; // [RULE17]
    end else begin
      lock_hit = block_lock_bits[blk]; // [RULE17]
    end
  end

  assign prot_hit = lvl_hit || lock_hit; // [RULE15]

  ////////////////////////////////////////////////////////////////////////////
  // Frame completion and acceptance
  logic frame_ok, exec, accept_op, soft_rst, rst_armed_q;

  assign frame_ok = state_q == fwpg_pkg::ST_DATA && bit_cnt_q == 3'h0 &&
    !extra_q && (!is_prog || data_cnt_q != '0); // [RULE3] [RULE7]
  assign exec = frame_end && frame_ok;
  assign accept_op = exec && alters && write_enable_latch_q &&
    !write_in_progress_flag_q && !prot_hit; // [RULE4] [RULE15] [RULE20]
  assign soft_rst = exec && cmd_q == fwpg_pkg::CMD_RESET_GO && rst_armed_q;

  // Reset must directly follow its arming frame
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rst_armed_q <= 1'b0;
    end else if (frame_end) begin
      rst_armed_q <= exec && cmd_q == fwpg_pkg::CMD_RESET_ARM;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n || soft_rst) begin
      write_enable_latch_q <= fwpg_pkg::RST_WEL;
    end else if (exec && cmd_q == fwpg_pkg::CMD_WRITE_ENABLE) begin
      write_enable_latch_q <= 1'b1; // [RULE4]
    end else if (exec && cmd_q == fwpg_pkg::CMD_WRITE_DISABLE) begin
      write_enable_latch_q <= 1'b0;
    end else if (accept_op) begin
      write_enable_latch_q <= 1'b0;
    end
  end

  // Entering power-down mid-operation is refused
  always_ff @(posedge clock) begin
    if (!rst_n || soft_rst) begin
      deep_power_down_q <= fwpg_pkg::RST_DPD;
    end else if (exec && cmd_q == fwpg_pkg::CMD_POWER_DOWN &&
                 !write_in_progress_flag_q) begin
      deep_power_down_q <= 1'b1;
    end else if (exec && cmd_q == fwpg_pkg::CMD_POWER_UP) begin
      deep_power_down_q <= 1'b0; // [RULE5]
    end
  end

  // Start wins over a finish in the same cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      write_in_progress_flag_q <= fwpg_pkg::RST_WIP;
    end else if (accept_op) begin
      write_in_progress_flag_q <= 1'b1; // [RULE12]
    end else if (op_done) begin
      write_in_progress_flag_q <= 1'b0; // [RULE12]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request to the internal program/erase and verify sequencer
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      op_start_q <= 1'b0;
      op_kind_q <= fwpg_pkg::KIND_PROG;
      op_addr_q <= '0;
      op_count_q <= '0;
    end else begin
      op_start_q <= accept_op; // [RULE7] [RULE11]
      if (accept_op) begin
        op_addr_q <= addr_q;
        op_count_q <= data_cnt_q; // [RULE9]
        if (is_prog) begin
          op_kind_q <= fwpg_pkg::KIND_PROG;
        end else if (is_sect) begin
          op_kind_q <= fwpg_pkg::KIND_SECTOR; // [RULE10]
        end else if (is_blk) begin
          op_kind_q <= fwpg_pkg::KIND_BLOCK; // [RULE10]
        end else begin
          op_kind_q <= fwpg_pkg::KIND_CHIP; // [RULE10]
        end
      end
    end
  end

  // Verify result of the sequencer, held until the next start
  always_ff @(posedge clock) begin
    if (!rst_n || accept_op) begin
      op_failed_q <= 1'b0;
    end else if (op_done && write_in_progress_flag_q && !op_verify_ok) begin
      op_failed_q <= 1'b1; // [RULE11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status strobes
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cmd_rejected_q <= 1'b0;
      standby_q <= fwpg_pkg::RST_STANDBY;
    end else begin
      cmd_rejected_q <= frame_end && state_q != fwpg_pkg::ST_STANDBY &&
                        (!frame_ok || (alters && !accept_op));
      standby_q <= cs_s2_q && !write_in_progress_flag_q; // [RULE8]
    end
  end

endmodule : fwpg_core

`default_nettype wire

//--- testbench/fwpg_host_model.sv
// Host model driving the flash link
`timescale 1ns/10ps
`default_nettype none
module fwpg_host_model (
  input wire logic clock,
  output logic cs_n_pin,
  output logic sclk_pin,
  output logic [7:0] sio_pin
);
  initial begin
    cs_n_pin = 1'h1;
    sclk_pin = 1'h0;
    sio_pin = 8'h5A;
  end
  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask : idle
  ////////////////////////////////////////////////////////////////////////////
  // Clock parks low between frames; 4 cycles per phase
  task automatic rise(input logic [7:0] v);
    sio_pin = v;
    idle(4);
    sclk_pin = 1'h1;
    idle(4);
    sclk_pin = 1'h0;
  endtask : rise
  task automatic frame(input logic oct, input logic [7:0] b[$],
                       input int tail);
    int i, k;
    cs_n_pin = 1'h0;
    idle(4);
    for (i = 0; i < b.size(); i++) begin
      if (oct) begin
        rise(b[i]);
      end else begin
        for (k = 7; k >= 0; k--) begin
          rise({~b[i][7:1], b[i][k]});
        end
      end
    end
    for (k = 0; k < tail; k++) begin
      rise(8'h01);
    end
    idle(2);
    cs_n_pin = 1'h1;
    // Released lines flip, not hold
    sio_pin = ~sio_pin;
    idle(8);
  endtask : frame
endmodule : fwpg_host_model
`default_nettype wire

//--- testbench/fwpg_core_sva.sv
// Concurrent checks on the gating core ports
`timescale 1ns/10ps
`default_nettype none
module fwpg_core_sva #(
  parameter int PAGE_AW = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cs_n_pin,
  input wire logic [3:0] protect_level_bits,
  input wire logic top_bottom_select,
  input wire logic op_done,
  input wire logic op_verify_ok,
  input wire logic op_start_q,
  input wire logic [1:0] op_kind_q,
  input wire logic [24:0] op_addr_q,
  input wire logic [PAGE_AW:0] op_count_q,
  input wire logic write_enable_latch_q,
  input wire logic write_in_progress_flag_q,
  input wire logic deep_power_down_q,
  input wire logic standby_q,
  input wire logic cmd_rejected_q,
  input wire logic op_failed_q
);
  int n;
  logic hit;
  always_comb begin
    n = (protect_level_bits >= 4'hA) ? 512 : (1 << protect_level_bits) / 2;
    hit = top_bottom_select ? (op_addr_q[24:16] < n) :
      (op_addr_q[24:16] >= 512 - n);
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_idle;
    (cs_n_pin && !write_in_progress_flag_q) [*4];
  endsequence
  sequence s_start;
    op_start_q && write_in_progress_flag_q ##1 !op_start_q;
  endsequence
  property p_reset;
    disable iff (1'h0) !rst_n |=> standby_q && !write_enable_latch_q &&
      !write_in_progress_flag_q && !deep_power_down_q;
  endproperty
  property p_standby;
    s_idle |-> standby_q;
  endproperty
  property p_active;
    !cs_n_pin [*4] |-> !standby_q;
  endproperty
  property p_start;
    op_start_q |-> s_start;
  endproperty
  property p_gate;
    op_start_q |-> $past(write_enable_latch_q) && !write_enable_latch_q;
  endproperty
  property p_done;
    write_in_progress_flag_q && op_done |=> !write_in_progress_flag_q &&
      (op_failed_q != $past(op_verify_ok));
  endproperty
  property p_dpd;
    deep_power_down_q && !write_enable_latch_q |=>
      !write_enable_latch_q && !op_start_q;
  endproperty
  property p_excl;
    op_start_q |-> !cmd_rejected_q;
  endproperty
  property p_all;
    op_start_q |-> protect_level_bits < 4'hA;
  endproperty
  property p_range;
    op_start_q && protect_level_bits != 4'h0 |-> !hit;
  endproperty
  property p_count;
    op_start_q |-> (op_kind_q == 2'h0) == (op_count_q != '0);
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
  a_standby: assert property (p_standby) else $error("no standby");
  a_active: assert property (p_active) else $error("standby in frame");
  a_start: assert property (p_start) else $error("bad start pulse");
  a_gate: assert property (p_gate) else $error("start without latch");
  a_done: assert property (p_done) else $error("bad completion");
  a_dpd: assert property (p_dpd) else $error("obeyed in power-down");
  a_excl: assert property (p_excl) else $error("start and refuse");
  a_all: assert property (p_all) else $error("all-protect broken");
  a_range: assert property (p_range) else $error("protected target");
  a_count: assert property (p_count) else $error("bad byte count");
endmodule : fwpg_core_sva
bind fwpg_core fwpg_core_sva #(.PAGE_AW(PAGE_AW)) u_fwpg_core_sva (.*);
`default_nettype wire

//--- testbench/fwpg_core_tb.sv
// Self-checking bench for the gating core
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin \
  compares++; \
  if ((got) !== (ex)) begin \
    err_total++; \
    $display("MISMATCH %s exp %0h got %0h", nm, ex, got); \
  end end
module fwpg_core_tb;
  logic clock, rst_n, cs_n_pin, sclk_pin, octal_mode, top_bottom_select;
  logic op_done, op_verify_ok, op_start_q, write_enable_latch_q;
  logic write_in_progress_flag_q, deep_power_down_q, standby_q;
  logic cmd_rejected_q, op_failed_q;
  logic [7:0] sio_pin, buf_rd_index, buf_rd_data_q;
  logic [3:0] protect_level_bits;
  logic [fwpg_pkg::BLOCKS-1:0] block_lock_bits;
  logic [15:0] sector_lock_bottom, sector_lock_top;
  logic [1:0] op_kind_q, kind_seen;
  logic [24:0] op_addr_q, addr_seen;
  logic [8:0] op_count_q, cnt_seen;
  int err_total, compares, n_start, n_rej, cycles;
  fwpg_core u_fwpg_core (.clock, .rst_n, .cs_n_pin, .sclk_pin, .sio_pin,
    .octal_mode, .protect_level_bits, .top_bottom_select, .block_lock_bits,
    .sector_lock_bottom, .sector_lock_top, .buf_rd_index, .op_done,
    .op_verify_ok, .op_start_q, .op_kind_q, .op_addr_q, .op_count_q,
    .buf_rd_data_q, .write_enable_latch_q, .write_in_progress_flag_q,
    .deep_power_down_q, .standby_q, .cmd_rejected_q, .op_failed_q);
  fwpg_host_model u_fwpg_host_model (.*);
  initial begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (op_start_q === 1'h1) begin
      n_start++;
      kind_seen <= op_kind_q;
      addr_seen <= op_addr_q;
      cnt_seen <= op_count_q;
    end
    if (cmd_rejected_q === 1'h1) n_rej++;
    if (cycles == 30000) begin
      err_total++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    if (err_total == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  // ok: 0 refused, 1 started, 2 neither
  task automatic send(input logic oct, input logic [7:0] b[$],
                      input int tail, input int ok);
    int s0, r0;
    s0 = n_start;
    r0 = n_rej;
    octal_mode = oct;
    u_fwpg_host_model.frame(oct, b, tail);
    `CHK("started", ok == 1, n_start - s0)
    `CHK("refused", ok == 0, n_rej - r0)
  endtask : send
  task automatic finish_op(input logic ok);
    op_verify_ok = ok;
    op_done = 1'h1;
    @(negedge clock);
    op_done = 1'h0;
    repeat (2) @(negedge clock);
    `CHK("busy", 1'h0, write_in_progress_flag_q)
    `CHK("failed", ~ok, op_failed_q)
    `CHK("standby", 1'h1, standby_q)
  endtask : finish_op
  function automatic logic prot(input logic [3:0] l, input logic t,
                                input logic [8:0] b);
    int k;
    k = (l == 4'h0) ? 0 : (l >= 4'hA) ? 512 : (1 << (l - 1));
    return t ? (b < k) : (b >= 512 - k);
  endfunction : prot
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    `CHK("standby", 1'h1, standby_q)
    `CHK("latch", 1'h0, write_enable_latch_q)
    `CHK("dpd", 1'h0, deep_power_down_q)
  endtask : t_reset
  task automatic t_prog_octal;
    send(1'h0, '{8'h06}, 0, 2);
    `CHK("latch", 1'h1, write_enable_latch_q)
    send(1'h1, '{8'h02, 8'hFD, 8'h00, 8'h00, 8'h01, 8'h00, 8'hAA, 8'hBB},
         0, 1);
    `CHK("kind", 2'h0, kind_seen)
    `CHK("addr", 25'h100, addr_seen)
    `CHK("count", 9'h002, cnt_seen)
    `CHK("latch", 1'h0, write_enable_latch_q)
    `CHK("wip", 1'h1, write_in_progress_flag_q)
    buf_rd_index = 8'h01;
    repeat (2) @(negedge clock);
    `CHK("buffer", 8'hBB, buf_rd_data_q)
    finish_op(1'h1);
  endtask : t_prog_octal
  task automatic t_refusals;
    send(1'h0, '{8'h20, 8'h00, 8'h10, 8'h00}, 0, 0);
    send(1'h0, '{8'h06}, 0, 2);
    send(1'h1, '{8'h20, 8'hE0, 8'h00, 8'h00, 8'h00, 8'h00}, 0, 0);
    send(1'h0, '{8'h06}, 3, 0);
    `CHK("latch", 1'h1, write_enable_latch_q)
    send(1'h0, '{8'h04}, 0, 2);
    `CHK("latch", 1'h0, write_enable_latch_q)
  endtask : t_refusals
  task automatic t_dpd;
    send(1'h0, '{8'hB9}, 0, 2);
    `CHK("dpd", 1'h1, deep_power_down_q)
    send(1'h0, '{8'h06}, 0, 0);
    `CHK("latch", 1'h0, write_enable_latch_q)
    send(1'h0, '{8'hAB}, 0, 2);
    `CHK("dpd", 1'h0, deep_power_down_q)
    send(1'h0, '{8'hB9}, 0, 2);
    send(1'h0, '{8'h66}, 0, 2);
    send(1'h0, '{8'h99}, 0, 2);
    `CHK("dpd", 1'h0, deep_power_down_q)
  endtask : t_dpd
  task automatic t_protect;
    // Packed as level, bottom select, block index
    logic [13:0] r [8] = '{14'h05FF, 14'h05FE, 14'h0E03, 14'h0E04,
                           14'h2500, 14'h24FF, 14'h3200, 14'h01FF};
    int i;
    logic p;
    for (i = 0; i < 8; i++) begin
      protect_level_bits = r[i][13:10];
      top_bottom_select = r[i][9];
      p = prot(r[i][13:10], r[i][9], r[i][8:0]);
      send(1'h0, '{8'h06}, 0, 2);
      send(1'h0, '{8'h21, {7'h00, r[i][8]}, r[i][7:0], 8'h00, 8'h10},
           0, !p);
      if (!p) finish_op(1'h1);
    end
    protect_level_bits = 4'h0;
    top_bottom_select = 1'h0;
  endtask : t_protect
  task automatic t_kinds;
    logic [7:0] c [8] = '{8'h02, 8'h12, 8'h20, 8'h21, 8'hD8, 8'hDC,
                          8'h60, 8'hC7};
    logic [7:0] b [$];
    int i;
    for (i = 0; i < 8; i++) begin
      send(1'h0, '{8'h06}, 0, 2);
      b = '{c[i], ~c[i], 8'h00, 8'h00, 8'h02, 8'h30};
      if (i < 2) b.push_back(8'h55);
      if (i >= 6) b = '{c[i], ~c[i]};
      send(1'h1, b, 0, 1);
      `CHK("kind", i / 2, kind_seen)
      `CHK("count", i < 2, cnt_seen)
      if (i < 6) `CHK("addr", 25'h230, addr_seen)
      finish_op(i != 7);
    end
  endtask : t_kinds
  initial begin
    rst_n = 1'h0;
    octal_mode = 1'h0;
    protect_level_bits = 4'h0;
    top_bottom_select = 1'h0;
    block_lock_bits = '0;
    sector_lock_bottom = 16'h0000;
    sector_lock_top = 16'h0000;
    buf_rd_index = 8'h00;
    op_done = 1'h0;
    op_verify_ok = 1'h1;
    repeat (6) @(negedge clock);
    rst_n = 1'h1;
    repeat (4) @(negedge clock);
    t_reset();
    t_prog_octal();
    t_refusals();
    t_dpd();
    t_protect();
    t_kinds();
    results();
  end
endmodule : fwpg_core_tb
`default_nettype wire
